// >>> rtl/acc_pkg.sv
package acc_pkg;
   // Register indices; byte address on the bus is four times the index.
   localparam logic [7:0] IDX_RES_LO = 8'h78;
   localparam logic [7:0] IDX_RES_HI = 8'h79;
   localparam logic [7:0] IDX_CTL    = 8'h7A;
   localparam logic [7:0] IDX_TRIG   = 8'h7B;
   localparam logic [7:0] IDX_MUX    = 8'h7C;
   localparam logic [7:0] IDX_DIS    = 8'h7E;

   // Bit positions in conversion_control_status.
   localparam int B_EN    = 7;
   localparam int B_START = 6;
   localparam int B_ATE   = 5;
   localparam int B_FLAG  = 4;
   localparam int B_IE    = 3;
   // Bit position of left_adjust in the channel register.
   localparam int B_LAR   = 5;

   localparam logic [7:0] CTL_RST  = 8'h00;
   localparam logic [7:0] TRIG_RST = 8'h00;
   localparam logic [7:0] MUX_RST  = 8'h00;
   localparam logic [7:0] DIS_RST  = 8'h00;

   // Converter clock cycles: 25 for the first conversion, 13 otherwise.
   localparam logic [4:0] CYC_FIRST = 5'h19;
   localparam logic [4:0] CYC_NORM  = 5'h0D;

   localparam logic [3:0] CH_TEMP = 4'h8;
   localparam logic [3:0] CH_BG   = 4'hE;
   localparam logic [3:0] CH_GND  = 4'hF;
   localparam logic [2:0] TS_FREE = 3'h0;

   // Division factor of the converter clock for a prescaler code.
   function automatic logic [7:0] acc_div_of(input logic [2:0] sel);
      acc_div_of = (sel < 3'h2) ? 8'h02 : 8'(8'h01 << sel);
   endfunction : acc_div_of
endpackage : acc_pkg

// >>> rtl/acc_conv_if.sv
interface acc_conv_if;
   logic       en;
   logic [2:0] div_sel;
   logic       tick;
   logic       start;
   logic       first;
   logic       busy;
   logic       done;

   modport pre (input en, input div_sel, output tick);
   modport seq (input en, input tick, input start, input first,
                output busy, output done);
   modport ctl (output en, output div_sel, output start, output first,
                input tick, input busy, input done);
endinterface : acc_conv_if

// >>> rtl/acc_prescaler.sv
module acc_prescaler
   import acc_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   acc_conv_if.pre   cv
);
   logic [6:0] cnt_ff;
   logic       tick_ff;
   logic [7:0] lim;
   logic       wrap;

   // A shrinking division mid-count must not run the counter up to 127.
   assign lim  = acc_div_of(cv.div_sel) - 8'h01;
   assign wrap = {1'b0, cnt_ff} >= lim;

   always_ff @(posedge clk_i) begin
      if (rst_i || !cv.en) begin
         cnt_ff  <= 7'h00;
         tick_ff <= 1'b0;
      end else begin
         cnt_ff  <= wrap ? 7'h00 : cnt_ff + 7'h01;
         tick_ff <= wrap;
      end
   end

   assign cv.tick = tick_ff;

   ////////////////////////////////////////////////////////////////////////
   logic [7:0] gap_ff;
   logic       seen_ff;
   logic [2:0] sel_ff;

   always_ff @(posedge clk_i) begin
      sel_ff <= cv.div_sel;
      if (rst_i || !cv.en || sel_ff != cv.div_sel) begin
         gap_ff  <= 8'h00;
         seen_ff <= 1'b0;
      end else begin
         gap_ff  <= tick_ff ? 8'h00 : gap_ff + 8'h01;
         seen_ff <= seen_ff | tick_ff;
      end
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_div_spacing: assert property (
      (tick_ff && seen_ff && sel_ff == cv.div_sel)
         |-> gap_ff == acc_div_of(cv.div_sel) - 8'h01)
      else $error("converter clock spacing wrong");
endmodule : acc_prescaler

// >>> rtl/acc_sequencer.sv
module acc_sequencer
   import acc_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   acc_conv_if.seq   cv
);
   logic [4:0] cnt_ff;
   logic       busy_ff;
   logic       done_ff;
   logic       last;

   assign last = busy_ff && cv.tick && cnt_ff == 5'h01;

   always_ff @(posedge clk_i) begin
      if (rst_i || !cv.en) begin
         cnt_ff  <= 5'h00;
         busy_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         done_ff <= last;
         if (cv.start && !busy_ff) begin
            busy_ff <= 1'b1;
            cnt_ff  <= cv.first ? CYC_FIRST : CYC_NORM;
         end else if (busy_ff && cv.tick) begin
            cnt_ff  <= cnt_ff - 5'h01;
            busy_ff <= !last;
         end
      end
   end

   assign cv.busy = busy_ff;
   assign cv.done = done_ff;

   ////////////////////////////////////////////////////////////////////////
   logic [4:0] tcnt_ff;
   logic [4:0] tgt_ff;

   always_ff @(posedge clk_i) begin
      if (cv.start && !busy_ff) begin
         tcnt_ff <= 5'h00;
         tgt_ff  <= cv.first ? CYC_FIRST : CYC_NORM;
      end else if (busy_ff && cv.tick) begin
         tcnt_ff <= tcnt_ff + 5'h01;
      end
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_conv_length: assert property (done_ff |-> tcnt_ff == tgt_ff)
      else $error("conversion length wrong");
endmodule : acc_sequencer

// >>> rtl/acc_top.sv
// Local design decision: register access over Wishbone.
module acc_top
   import acc_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [9:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        gie_i,
   input  wire logic        irq_ack_i,
   output logic             irq_o,
   input  wire logic [6:0]  trig_flags_i,
   input  wire logic [9:0]  core_result_i,
   output logic             core_on_o,
   output logic             core_start_o,
   output logic             core_tick_o,
   output logic             core_busy_o,
   output logic      [3:0]  ch_sel_o,
   output logic      [7:0]  in_sel_o,
   output logic             temp_sel_o,
   output logic             bandgap_input_sel_o,
   output logic             gnd_sel_o,
   input  wire logic [5:0]  pin_i,
   output logic      [5:0]  pin_in_o,
   output logic      [5:0]  buffer_off_o
);
   acc_conv_if cv ();

   logic        en_ff;
   logic        ate_ff;
   logic        flag_ff;
   logic        ie_ff;
   logic [2:0]  ps_ff;
   logic        start_ff;
   logic        first_ff;
   logic [2:0]  src_ff;
   logic        lar_ff;
   logic [3:0]  ch_ff;
   logic [3:0]  ch_act_ff;
   logic [10:0] dec_ff;
   logic [5:0]  dis_ff;
   logic [9:0]  res_ff;
   logic        lock_ff;
   logic        trig_prev_ff;
   logic        irq_ff;
   logic [5:0]  pin_s1_ff;
   logic [5:0]  pin_s2_ff;
   logic [5:0]  pin_in_ff;
   logic        ack_ff;
   logic [31:0] dat_ff;

   ////////////////////////////////////////////////////////////////////////
   // Bus decode. The answer comes one cycle after the request; writes and
   // read side effects act on the edge at which the master sees ack.
   wire       req    = wb_cyc_i & wb_stb_i;
   wire [7:0] idx    = wb_adr_i[9:2];
   wire [7:0] wd     = wb_dat_i[7:0];
   wire       wr     = req & ack_ff & wb_we_i & wb_sel_i[0];
   wire       rd     = req & ack_ff & ~wb_we_i;
   wire       hit_lo = idx == IDX_RES_LO;
   wire       hit_hi = idx == IDX_RES_HI;
   wire       hit_ct = idx == IDX_CTL;
   wire       hit_tr = idx == IDX_TRIG;
   wire       hit_mx = idx == IDX_MUX;
   wire       hit_ds = idx == IDX_DIS;
   wire       ctl_wr = wr & hit_ct;
   wire       tr_wr  = wr & hit_tr;
   wire       mx_wr  = wr & hit_mx;
   wire       ds_wr  = wr & hit_ds;

   ////////////////////////////////////////////////////////////////////////
   // Starting conversions.
   wire conv_act = cv.busy | start_ff;
   wire nxt_en   = ctl_wr ? wd[B_EN] : en_ff;
   wire en_rise  = nxt_en & ~en_ff;
   // A start may share its write with the enable.
   wire sw_go    = ctl_wr & wd[B_START] & wd[B_EN];
   wire trig_raw = (src_ff == TS_FREE) ? 1'b0
                   : trig_flags_i[src_ff - 3'h1];
   // The previous level follows the selected source, so a switch to a
   // source whose flag is set looks like a rising edge.
   wire auto_go  = ate_ff & trig_raw & ~trig_prev_ff;
   wire free_go  = ate_ff & (src_ff == TS_FREE) & cv.done;
   wire go       = (sw_go | auto_go | free_go) & ~conv_act & nxt_en;

   assign cv.en      = en_ff;
   assign cv.div_sel = ps_ff;
   assign cv.start   = start_ff;
   assign cv.first   = first_ff;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         start_ff     <= 1'b0;
         first_ff     <= 1'b0;
         trig_prev_ff <= 1'b0;
      end else begin
         start_ff     <= go;
         trig_prev_ff <= trig_raw;
         if (!nxt_en) begin
            first_ff <= 1'b0;
         end else if (en_rise) begin
            first_ff <= 1'b1;
         end else if (start_ff) begin
            first_ff <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Control registers. The done flag is set by hardware with priority
   // over both clears, so a completion in the clearing cycle survives.
   wire w1c_flag = ctl_wr & wd[B_FLAG];
   wire nxt_flag = cv.done | (flag_ff & ~w1c_flag & ~irq_ack_i);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_ff   <= CTL_RST[B_EN];
         ate_ff  <= CTL_RST[B_ATE];
         flag_ff <= CTL_RST[B_FLAG];
         ie_ff   <= CTL_RST[B_IE];
         ps_ff   <= CTL_RST[2:0];
      end else begin
         en_ff   <= nxt_en;
         flag_ff <= nxt_flag;
         if (ctl_wr) begin
            ate_ff <= wd[B_ATE];
            ie_ff  <= wd[B_IE];
            ps_ff  <= wd[2:0];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         src_ff <= TRIG_RST[2:0];
         lar_ff <= MUX_RST[B_LAR];
         ch_ff  <= MUX_RST[3:0];
         dis_ff <= DIS_RST[5:0];
      end else begin
         if (tr_wr) begin
            src_ff <= wd[2:0];
         end
         if (mx_wr) begin
            lar_ff <= wd[B_LAR];
            ch_ff  <= wd[3:0];
         end
         if (ds_wr) begin
            dis_ff <= wd[5:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Channel in use and its decode for the analog multiplexer.
   wire [3:0]  nxt_ch_act = conv_act ? ch_act_ff : ch_ff;
   wire [7:0]  pin_dec    = ch_act_ff[3] ? 8'h00
                            : 8'(8'h01 << ch_act_ff[2:0]);
   wire [10:0] nxt_dec    = {ch_act_ff == CH_GND, ch_act_ff == CH_BG,
                             ch_act_ff == CH_TEMP, pin_dec};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ch_act_ff <= MUX_RST[3:0];
         dec_ff    <= 11'h000;
      end else begin
         ch_act_ff <= nxt_ch_act;
         dec_ff    <= nxt_dec;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Result capture. Reading the low byte locks the pair until the high
   // byte is read; a conversion ending meanwhile is dropped.
   wire nxt_lock = (rd & hit_lo) | (lock_ff & ~(rd & hit_hi));

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         res_ff  <= 10'h000;
         lock_ff <= 1'b0;
      end else begin
         lock_ff <= nxt_lock;
         if (cv.done && !lock_ff) begin
            res_ff <= core_result_i;
         end
      end
   end

   // Alignment is applied on the read path, so it follows left_adjust
   // at once.
   wire [7:0] lo_val = lar_ff ? {res_ff[1:0], 6'h00}
                       : res_ff[7:0];
   wire [7:0] hi_val = lar_ff ? res_ff[9:2]
                       : {6'h00, res_ff[9:8]};
   wire [7:0] ct_val = {en_ff, conv_act, ate_ff, flag_ff,
                        ie_ff, ps_ff};
   wire [7:0] rsel   = hit_lo ? lo_val
                     : hit_hi ? hi_val
                     : hit_ct ? ct_val
                     : hit_tr ? {5'h00, src_ff}
                     : hit_mx ? {2'h0, lar_ff, 1'b0, ch_ff}
                     : hit_ds ? {2'h0, dis_ff}
                     : 8'h00;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h0000_0000;
      end else begin
         ack_ff <= req & ~ack_ff;
         if (req && !ack_ff) begin
            dat_ff <= {24'h00_0000, rsel};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt request and pin inputs.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_ff    <= 1'b0;
         pin_s1_ff <= 6'h00;
         pin_s2_ff <= 6'h00;
         pin_in_ff <= 6'h00;
      end else begin
         irq_ff    <= flag_ff & ie_ff & gie_i;
         pin_s1_ff <= pin_i;
         pin_s2_ff <= pin_s1_ff;
         pin_in_ff <= pin_s2_ff & ~dis_ff;
      end
   end

   acc_prescaler u_pre (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .cv    (cv.pre)
   );

   acc_sequencer u_seq (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .cv    (cv.seq)
   );

   assign wb_dat_o            = dat_ff;
   assign wb_ack_o            = ack_ff;
   assign irq_o               = irq_ff;
   assign core_on_o           = en_ff;
   assign core_start_o        = start_ff;
   assign core_tick_o         = cv.tick;
   assign core_busy_o         = cv.busy;
   assign ch_sel_o            = ch_act_ff;
   assign in_sel_o            = dec_ff[7:0];
   assign temp_sel_o          = dec_ff[8];
   assign bandgap_input_sel_o = dec_ff[9];
   assign gnd_sel_o           = dec_ff[10];
   assign pin_in_o            = pin_in_ff;
   assign buffer_off_o        = dis_ff;

   ////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_free_done;
      cv.done && ate_ff && src_ff == TS_FREE && en_ff && !ctl_wr;
   endsequence

   sequence s_restart;
      core_start_o ##1 cv.busy;
   endsequence

   a_chan_hold: assert property (
      (cv.busy && $past(cv.busy)) |-> $stable(ch_sel_o))
      else $error("channel changed during conversion");

   a_chan_decode: assert property (
      (ch_sel_o == CH_BG && $stable(ch_sel_o))
         |=> bandgap_input_sel_o && !gnd_sel_o && in_sel_o == 8'h00)
      else $error("bandgap decode wrong");

   a_abort_off: assert property (!en_ff |=> !cv.busy)
      else $error("conversion survived disable");

   a_start_reads: assert property (
      (req && !ack_ff && !wb_we_i && hit_ct && cv.busy)
         |=> wb_ack_o && wb_dat_o[B_START])
      else $error("start bit not read as busy");

   a_trig_start: assert property (
      (auto_go && !conv_act && en_ff && !ctl_wr)
         |=> core_start_o ##1 cv.busy)
      else $error("trigger edge did not start");

   a_flag_done: assert property (cv.done |=> flag_ff)
      else $error("flag not set on completion");

   a_irq_gate: assert property (
      (flag_ff && ie_ff && gie_i) |=> irq_o)
      else $error("interrupt not requested");

   a_irq_mask: assert property ((!ie_ff || !gie_i) |=> !irq_o)
      else $error("masked interrupt requested");

   a_flag_clear: assert property (
      (w1c_flag && !cv.done) |=> !flag_ff)
      else $error("flag not cleared by write");

   a_res_locked: assert property (
      (lock_ff && !(rd && hit_hi)) |=> $stable(res_ff))
      else $error("locked result changed");

   a_pin_block: assert property (
      (dis_ff != 6'h00) |=> (pin_in_o & $past(dis_ff)) == 6'h00)
      else $error("disabled pin reads one");

   a_free_rerun: assert property (s_free_done |=> s_restart)
      else $error("free running did not restart");
endmodule : acc_top

// >>> bench/acc_core_model.sv
module acc_core_model
   import acc_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       start_i,
   input  wire logic       busy_i,
   input  wire logic [3:0] ch_i,
   output logic      [9:0] result_o
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [9:0] res_ff;
   logic [1:0] hold_ff;

   // The result tags its channel; outside the hold window it is inverted,
   // so a sample taken too late shows up as a wrong value.
   assign result_o = (hold_ff != 2'h0) ? res_ff : ~res_ff;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         res_ff  <= 10'h000;
         hold_ff <= 2'h0;
      end else if (start_i) begin
         res_ff  <= {ch_i, 6'h2A};
         hold_ff <= 2'h3;
      end else if (busy_i) begin
         hold_ff <= 2'h3;
      end else if (hold_ff != 2'h0) begin
         hold_ff <= hold_ff - 2'h1;
      end
   end
endmodule : acc_core_model

// >>> bench/adc_conversion_control_test.sv
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
   $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module adc_conversion_control_test
   import acc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic        clk_i = 1'b0, rst_i = 1'b1, gie_i = 1'b1, irq_ack_i = 1'b0;
   logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [9:0]  wb_adr_i = 10'h000;
   logic [3:0]  wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic [6:0]  trig_flags_i = 7'h00;
   logic [5:0]  pin_i = 6'h00, pin_in_o, buffer_off_o;
   logic [9:0]  core_result_i;
   logic [7:0]  in_sel_o, q;
   logic [3:0]  ch_sel_o;
   logic [2:0]  sel_bits;
   logic        wb_ack_o, irq_o, core_on_o, core_start_o, core_tick_o;
   logic        core_busy_o, temp_sel_o, bandgap_input_sel_o, gnd_sel_o;
   int          n_fail = 0, comparisons = 0, t, g, k;

   always #25 clk_i = ~clk_i;

   acc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .gie_i(gie_i), .irq_ack_i(irq_ack_i),
      .irq_o(irq_o), .trig_flags_i(trig_flags_i),
      .core_result_i(core_result_i), .core_on_o(core_on_o),
      .core_start_o(core_start_o), .core_tick_o(core_tick_o),
      .core_busy_o(core_busy_o), .ch_sel_o(ch_sel_o), .in_sel_o(in_sel_o),
      .temp_sel_o(temp_sel_o), .bandgap_input_sel_o(bandgap_input_sel_o),
      .gnd_sel_o(gnd_sel_o), .pin_i(pin_i), .pin_in_o(pin_in_o),
      .buffer_off_o(buffer_off_o));

   acc_core_model core (.clk_i(clk_i), .rst_i(rst_i), .start_i(core_start_o),
      .busy_i(core_busy_o), .ch_i(ch_sel_o), .result_o(core_result_i));

   ////////////////////////////////////////////////////////////////////////
   task results;
      $display("mismatches %0d comparisons %0d", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : results

   task automatic wb_acc(input logic w, input logic [7:0] a, d);
      int i;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= {a, 2'b00};
      wb_dat_i <= {24'h0, d};
      for (i = 0; i < 20; i++) begin
         @(posedge clk_i);
         if (wb_ack_o === 1'b1) break;
      end
      q = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
      if (i == 20) begin n_fail++; results(); end
   endtask : wb_acc

   task automatic wr(input logic [7:0] a, d);
      wb_acc(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, e);
      wb_acc(1'b0, a, 8'h00);
      `CHK(q, e)
   endtask : rd

   task automatic wait_start(input int lim, output int r);
      r = -1;
      for (int i = 0; i < lim; i++) begin
         @(negedge clk_i);
         if (core_start_o === 1'b1) begin r = i; break; end
      end
   endtask : wait_start

   // Counts converter ticks seen while busy, then lets the flag settle.
   task automatic run_out(output int n);
      int i;
      n = 0;
      for (i = 0; i < 4000; i++) begin
         @(negedge clk_i);
         if (core_busy_o === 1'b1 && core_tick_o === 1'b1) n++;
         if (core_busy_o === 1'b0 && i > 1) break;
      end
      if (i == 4000) begin n_fail++; results(); end
      repeat (3) @(negedge clk_i);
   endtask : run_out

   task automatic conv(input logic [7:0] c, output int n);
      wr(IDX_CTL, c);
      wait_start(8, g);
      `CHK(g >= 0, 1'b1)
      run_out(n);
   endtask : conv

   task automatic tick_gap(output int n);
      int i;
      n = 0;
      for (i = 0; i < 300; i++) begin
         @(negedge clk_i);
         if (core_tick_o === 1'b1) break;
      end
      do begin @(negedge clk_i); n++; end
      while (core_tick_o !== 1'b1 && n < 300);
   endtask : tick_gap

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(IDX_RES_LO, 8'h00);
      rd(IDX_RES_HI, 8'h00);
      rd(IDX_CTL, 8'h00);
      rd(8'h7D, 8'h00);
      for (k = 0; k < 16; k++) begin
         wr(IDX_MUX, 8'(k));
         repeat (3) @(negedge clk_i);
         sel_bits = {temp_sel_o, bandgap_input_sel_o, gnd_sel_o};
         `CHK(ch_sel_o, 4'(k))
         `CHK(in_sel_o, (k < 8) ? 8'(1 << k) : 8'h00)
         `CHK(sel_bits, {k == 8, k == 14, k == 15})
      end
      @(posedge clk_i) pin_i <= 6'h2D;
      wr(IDX_DIS, 8'h0F);
      repeat (4) @(negedge clk_i);
      `CHK(pin_in_o, 6'h20)
      `CHK(buffer_off_o, 6'h0F)
      wr(IDX_DIS, 8'h00);
      repeat (4) @(negedge clk_i);
      `CHK(pin_in_o, 6'h2D)
      wr(IDX_TRIG, 8'h05);
      rd(IDX_TRIG, 8'h05);
      for (k = 0; k < 8; k++) begin
         wr(IDX_CTL, 8'h80 | 8'(k));
         tick_gap(t);
         `CHK(t, (k < 2) ? 2 : (1 << k))
      end
      `CHK(core_on_o, 1'b1)
      wr(IDX_CTL, 8'h00);
      @(negedge clk_i);
      `CHK(core_on_o, 1'b0)
      wr(IDX_TRIG, 8'h00);
      wr(IDX_MUX, 8'h03);
      conv(8'hC0, t);
      `CHK(t, 25)
      wait_start(10, g);
      `CHK(g, -1)
      rd(IDX_CTL, 8'h90);
      rd(IDX_RES_LO, 8'hEA);
      rd(IDX_RES_HI, 8'h00);
      wr(IDX_MUX, 8'h23);
      rd(IDX_RES_HI, 8'h3A);
      rd(IDX_RES_LO, 8'h80);
      // The low read above locks the bytes, so this result must be lost.
      wr(IDX_MUX, 8'h25);
      conv(8'hC0, t);
      `CHK(t, 13)
      rd(IDX_RES_HI, 8'h3A);
      wr(IDX_MUX, 8'h05);
      wr(IDX_CTL, 8'hC0);
      wait_start(8, g);
      `CHK(g >= 0, 1'b1)
      rd(IDX_CTL, 8'hD0);
      wr(IDX_MUX, 8'h03);
      @(negedge clk_i);
      `CHK(ch_sel_o, 4'h5)
      run_out(t);
      `CHK(ch_sel_o, 4'h3)
      rd(IDX_RES_LO, 8'h6A);
      rd(IDX_RES_HI, 8'h01);
      wr(IDX_CTL, 8'h80);
      rd(IDX_CTL, 8'h90);
      wr(IDX_CTL, 8'h90);
      rd(IDX_CTL, 8'h80);
      conv(8'hC0, t);
      `CHK(t, 13)
      repeat (2) @(negedge clk_i);
      `CHK(irq_o, 1'b0)
      wr(IDX_CTL, 8'h88);
      repeat (2) @(negedge clk_i);
      `CHK(irq_o, 1'b1)
      @(posedge clk_i) gie_i <= 1'b0;
      repeat (2) @(negedge clk_i);
      `CHK(irq_o, 1'b0)
      @(posedge clk_i) gie_i <= 1'b1;
      @(posedge clk_i) irq_ack_i <= 1'b1;
      @(posedge clk_i) irq_ack_i <= 1'b0;
      repeat (2) @(negedge clk_i);
      `CHK(irq_o, 1'b0)
      rd(IDX_CTL, 8'h88);
      wr(IDX_CTL, 8'hC0);
      repeat (6) @(negedge clk_i);
      wr(IDX_CTL, 8'h00);
      repeat (2) @(negedge clk_i);
      `CHK(core_busy_o, 1'b0)
      `CHK(core_on_o, 1'b0)
      repeat (80) @(negedge clk_i);
      rd(IDX_CTL, 8'h00);
      wr(IDX_CTL, 8'hB0);
      for (k = 1; k < 8; k++) begin
         wr(IDX_TRIG, 8'(k));
         @(posedge clk_i) trig_flags_i <= 7'(1 << (k % 7));
         wait_start(10, g);
         `CHK(g, -1)
         @(posedge clk_i) trig_flags_i <= 7'(1 << (k - 1));
         wait_start(10, g);
         `CHK(g >= 0, 1'b1)
         run_out(t);
         `CHK(t, (k == 1) ? 25 : 13)
         @(posedge clk_i) trig_flags_i <= 7'h00;
      end
      wr(IDX_TRIG, 8'h01);
      @(posedge clk_i) trig_flags_i <= 7'h02;
      wait_start(10, g);
      `CHK(g, -1)
      wr(IDX_TRIG, 8'h02);
      wait_start(10, g);
      `CHK(g >= 0, 1'b1)
      run_out(t);
      wr(IDX_TRIG, 8'h00);
      wait_start(10, g);
      `CHK(g, -1)
      @(posedge clk_i) trig_flags_i <= 7'h00;
      wr(IDX_CTL, 8'hF0);
      t = 0;
      repeat (100) begin
         @(negedge clk_i);
         if (core_start_o === 1'b1) t++;
      end
      `CHK(t >= 3, 1'b1)
      // A reset in mid-conversion must bring core_on_o, core_busy_o and irq_o back to idle.
      @(posedge clk_i) rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(negedge clk_i);
      `CHK({core_on_o, core_busy_o, irq_o}, 3'h0)
      rd(IDX_CTL, 8'h00);
      wr(IDX_CTL, 8'h00);
      results();
   end
endmodule : adc_conversion_control_test
